//--- src/rpm_pkg.sv
/*
 Constants shared by the receive pattern-match configuration block.
 Assumes a 32-bit AXI4-Lite register bus; register indices are scaled by four.
*/
// Notes on behaviour
// - Word at 0x159 holds bytes 58, 59
// - Word at 0x15a holds bytes 60, 61
// - Word at 0x15b holds bytes 62, 63
// - Each pattern byte has its own mask bit
// - Masks 0x15c, 0x15d cover bytes 0-31, reset zero
// - Masks 0x15e, 0x15f cover bytes 32-63
// - Mask bit one drops byte from compare
// - Six-bit start offset at 0x161, reset zero
// - Offset bits 15:6 read zero, ignore writes
// - Earlier words hold ascending byte pairs
`default_nettype none
package rpm_pkg;
	localparam int unsigned REG_W = 16;
	localparam int unsigned NUM_BYTES = 64;
	localparam int unsigned NUM_PAT_WORDS = 32;
	localparam int unsigned NUM_MASK_WORDS = 4;
	localparam int unsigned OFS_W = 6;
	localparam int unsigned ADDR_W = 12;
	// Register indices (byte address is index times four)
	localparam logic [9:0] IDX_PAT_FIRST = 10'h13c;
	localparam logic [9:0] IDX_PAT_58_59 = 10'h159;
	localparam logic [9:0] IDX_PAT_60_61 = 10'h15a;
	localparam logic [9:0] IDX_PAT_62_63 = 10'h15b;
	localparam logic [9:0] IDX_MASK_0_15 = 10'h15c;
	localparam logic [9:0] IDX_MASK_16_31 = 10'h15d;
	localparam logic [9:0] IDX_MASK_32_47 = 10'h15e;
	localparam logic [9:0] IDX_MASK_48_63 = 10'h15f;
	localparam logic [9:0] IDX_START_OFS = 10'h161;
	localparam logic [15:0] PAT_RESET = 16'h0000;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [5:0] OFS_RESET = 6'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- src/rpm_axil_slave.sv
/*
 AXI4-Lite slave front end: one write and one read in flight, each answered
 one cycle after both halves are held. Presents a one-cycle register strobe.
 Assumes the master follows AXI4-Lite handshake rules.
*/
`timescale 1ns/1ps
`default_nettype none
module rpm_axil_slave #(
	parameter int unsigned ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [9:0] wr_idx,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic [1:0] wr_resp,
	output logic [9:0] rd_idx,
	input wire logic [31:0] rd_data,
	input wire logic [1:0] rd_resp
);
	typedef struct packed {
		logic aw_held;
		logic w_held;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic awready;
		logic wready;
		logic arready;
	} rpm_axs_type;

	rpm_axs_type s_q, s_d;

	if (ADDR_W < 12) begin : g_bad_addr_w
		$error("ADDR_W too small for register map");
	end

	always_comb begin
		s_d = s_q;
		if (s_axi_awvalid && !s_q.aw_held && !s_q.bvalid) begin
			s_d.aw_held = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_held && !s_q.bvalid) begin
			s_d.w_held = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		// Strobe fires once both halves are held; response is raised the cycle after it
		if (s_q.aw_held && s_q.w_held) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_resp;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// Read: capture address, answer next cycle from the decoded word
		if (s_axi_arvalid && !s_q.arvalid && !s_q.rvalid) begin
			s_d.arvalid = 1'b1;
			s_d.araddr = s_axi_araddr;
		end
		if (s_q.arvalid) begin
			s_d.arvalid = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_data;
			s_d.rresp = rd_resp;
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		// Ready bits are registered copies so every bus output leaves a flip-flop
		s_d.awready = !s_d.aw_held && !s_d.bvalid;
		s_d.wready = !s_d.w_held && !s_d.bvalid;
		s_d.arready = !s_d.arvalid && !s_d.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign wr_en = s_q.aw_held && s_q.w_held;
	assign wr_idx = s_q.awaddr[11:2];
	assign wr_data = s_q.wdata;
	assign wr_strb = s_q.wstrb;
	assign rd_idx = s_q.araddr[11:2];
endmodule
`default_nettype wire

//--- src/rpm_comparator.sv
/*
 Pattern comparator: walks received bytes after the start delimiter and
 reports a match when every unmasked pattern byte equals its received byte.
 Assumes rx_sof marks the first byte after the delimiter, bytes on rx_valid.
*/
`timescale 1ns/1ps
`default_nettype none
module rpm_comparator #(
	parameter int unsigned NUM_BYTES = 64
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [NUM_BYTES*8-1:0] pattern,
	input wire logic [NUM_BYTES-1:0] byte_mask,
	input wire logic [5:0] start_ofs,
	input wire logic rx_sof,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_eof,
	output logic match,
	output logic match_done
);
	typedef enum {ST_IDLE, ST_SKIP, ST_CMP, ST_WAIT} rpm_cst_type;
	typedef struct packed {
		rpm_cst_type st;
		logic [6:0] cnt;
		logic ok;
		logic match;
		logic done;
	} rpm_cmp_type;

	rpm_cmp_type c_q, c_d;
	logic [7:0] pat_byte;
	logic byte_ok;

	if (NUM_BYTES != 64) begin : g_bad_bytes
		$error("NUM_BYTES must be 64");
	end

	assign pat_byte = pattern[c_q.cnt[5:0]*8 +: 8];
	assign byte_ok = byte_mask[c_q.cnt[5:0]] || (rx_byte == pat_byte);

	always_comb begin
		c_d = c_q;
		c_d.done = 1'b0;
		case (c_q.st)
			ST_IDLE: begin
				if (rx_sof && rx_valid) begin
					c_d.ok = 1'b1;
					if (start_ofs == 6'h00) begin
						c_d.cnt = 7'h01;
						c_d.ok = byte_mask[0] || (rx_byte == pattern[7:0]);
						c_d.st = ST_CMP;
					end else begin
						c_d.cnt = 7'h01;
						c_d.st = ST_SKIP;
					end
				end
			end
			ST_SKIP: begin
				if (rx_eof) begin
					c_d.st = ST_IDLE;
				end else if (rx_valid) begin
					if (c_q.cnt[5:0] == start_ofs) begin
						c_d.cnt = 7'h01;
						c_d.ok = byte_mask[0] || (rx_byte == pattern[7:0]);
						c_d.st = ST_CMP;
					end else begin
						c_d.cnt = c_q.cnt + 7'h01;
					end
				end
			end
			ST_CMP: begin
				if (c_q.cnt == 7'h40) begin
					c_d.match = c_q.ok;
					c_d.done = 1'b1;
					// An end mark on the byte after the window must not be lost
					c_d.st = rx_eof ? ST_IDLE : ST_WAIT;
				end else if (rx_eof) begin
					c_d.match = 1'b0;
					c_d.done = 1'b1;
					c_d.st = ST_IDLE;
				end else if (rx_valid) begin
					c_d.ok = c_q.ok && byte_ok;
					c_d.cnt = c_q.cnt + 7'h01;
				end
			end
			ST_WAIT: begin
				if (rx_eof) begin
					c_d.st = ST_IDLE;
				end
			end
			default: begin
				c_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c_q <= '{st: ST_IDLE, default: '0};
		end else begin
			c_q <= c_d;
		end
	end

	assign match = c_q.match;
	assign match_done = c_q.done;
endmodule
`default_nettype wire

//--- src/rpm_top.sv
/*
 Receive pattern-match configuration store: 32 pattern words, four byte
 mask words and the compare start offset, reached over AXI4-Lite, feeding
 the receive-path comparator.
 Assumes one clock; receive byte stream already in that clock domain.
*/
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rpm_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_sof,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_eof,
	output logic match,
	output logic match_done
);
	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [rpm_pkg::NUM_PAT_WORDS-1:0][15:0] pat;
		logic [rpm_pkg::NUM_MASK_WORDS-1:0][15:0] mask;
		logic [5:0] ofs;
		logic match;
		logic done;
	} rpm_regs_type;

	rpm_regs_type r_q, r_d;
	logic wr_en;
	logic [9:0] wr_idx;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [9:0] rd_idx;
	logic [31:0] rd_data;
	logic [1:0] rd_resp;
	logic [1:0] wr_resp;
	logic [9:0] wr_pat_rel;
	logic [9:0] rd_pat_rel;
	logic [9:0] wr_mask_rel;
	logic [9:0] rd_mask_rel;
	logic wr_is_pat, wr_is_mask, wr_is_ofs;
	logic rd_is_pat, rd_is_mask, rd_is_ofs;
	logic cmp_match, cmp_done;

	// ----------------------------------------------------------------
	// Bus front end
	// ----------------------------------------------------------------
	rpm_axil_slave #(
		.ADDR_W(rpm_pkg::ADDR_W)
	) i_rpm_axil_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_resp(wr_resp),
		.rd_idx(rd_idx),
		.rd_data(rd_data),
		.rd_resp(rd_resp)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Pattern words sit at ascending indices, two bytes each
	assign wr_pat_rel = wr_idx - rpm_pkg::IDX_PAT_FIRST;
	assign rd_pat_rel = rd_idx - rpm_pkg::IDX_PAT_FIRST;
	assign wr_mask_rel = wr_idx - rpm_pkg::IDX_MASK_0_15;
	assign rd_mask_rel = rd_idx - rpm_pkg::IDX_MASK_0_15;
	// Pattern range ends at IDX_PAT_62_63, covering 58..63 at 0x159..0x15b
	assign wr_is_pat = (wr_idx >= rpm_pkg::IDX_PAT_FIRST) && (wr_idx <= rpm_pkg::IDX_PAT_62_63);
	assign rd_is_pat = (rd_idx >= rpm_pkg::IDX_PAT_FIRST) && (rd_idx <= rpm_pkg::IDX_PAT_62_63);
	assign wr_is_mask = (wr_idx >= rpm_pkg::IDX_MASK_0_15) && (wr_idx <= rpm_pkg::IDX_MASK_48_63);
	assign rd_is_mask = (rd_idx >= rpm_pkg::IDX_MASK_0_15) && (rd_idx <= rpm_pkg::IDX_MASK_48_63);
	assign wr_is_ofs = (wr_idx == rpm_pkg::IDX_START_OFS);
	assign rd_is_ofs = (rd_idx == rpm_pkg::IDX_START_OFS);
	assign wr_resp = (wr_is_pat || wr_is_mask || wr_is_ofs) ? rpm_pkg::RESP_OKAY : rpm_pkg::RESP_SLVERR;

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.match = cmp_match;
		r_d.done = cmp_done;
		if (wr_en && wr_is_pat) begin
			// Lower-numbered byte in lane 0
			if (wr_strb[0]) begin
				r_d.pat[wr_pat_rel[4:0]][7:0] = wr_data[7:0];
			end
			if (wr_strb[1]) begin
				r_d.pat[wr_pat_rel[4:0]][15:8] = wr_data[15:8];
			end
		end
		if (wr_en && wr_is_mask) begin
			if (wr_strb[0]) begin
				r_d.mask[wr_mask_rel[1:0]][7:0] = wr_data[7:0];
			end
			if (wr_strb[1]) begin
				r_d.mask[wr_mask_rel[1:0]][15:8] = wr_data[15:8];
			end
		end
		// Upper bits of the offset word are dropped on write
		if (wr_en && wr_is_ofs && wr_strb[0]) begin
			r_d.ofs = wr_data[5:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < rpm_pkg::NUM_PAT_WORDS; i++) begin
				r_q.pat[i] <= rpm_pkg::PAT_RESET;
			end
			for (int i = 0; i < rpm_pkg::NUM_MASK_WORDS; i++) begin
				r_q.mask[i] <= rpm_pkg::MASK_RESET;
			end
			r_q.ofs <= rpm_pkg::OFS_RESET;
			r_q.match <= 1'b0;
			r_q.done <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 32'h00000000;
		rd_resp = rpm_pkg::RESP_OKAY;
		if (rd_is_pat) begin
			rd_data = {16'h0000, r_q.pat[rd_pat_rel[4:0]]};
		end else if (rd_is_mask) begin
			rd_data = {16'h0000, r_q.mask[rd_mask_rel[1:0]]};
		end else if (rd_is_ofs) begin
			rd_data = {26'h0000000, r_q.ofs};
		end else begin
			rd_resp = rpm_pkg::RESP_SLVERR;
		end
	end

	// ----------------------------------------------------------------
	// Comparator
	// ----------------------------------------------------------------
	logic [rpm_pkg::NUM_BYTES*8-1:0] pat_flat;
	logic [rpm_pkg::NUM_BYTES-1:0] mask_flat;

	genvar g;
	generate
		for (g = 0; g < rpm_pkg::NUM_PAT_WORDS; g++) begin : g_pat
			assign pat_flat[g*16 +: 16] = r_q.pat[g];
		end
	endgenerate
	assign mask_flat = r_q.mask;

	rpm_comparator #(
		.NUM_BYTES(rpm_pkg::NUM_BYTES)
	) i_rpm_comparator (
		.aclk(aclk),
		.aresetn(aresetn),
		.pattern(pat_flat),
		.byte_mask(mask_flat),
		.start_ofs(r_q.ofs),
		.rx_sof(rx_sof),
		.rx_valid(rx_valid),
		.rx_byte(rx_byte),
		.rx_eof(rx_eof),
		.match(cmp_match),
		.match_done(cmp_done)
	);

	assign match = r_q.match;
	assign match_done = r_q.done;
endmodule
`default_nettype wire

//--- verif/rpm_top_checker.sv
/*
 Assertions on the bus handshake and comparator outputs of rpm_top.
 Assumes it is bound to rpm_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module rpm_top_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic match,
	input wire logic match_done
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Handshake steps
	// ----------------------------------------
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted with response pending");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted with data pending");
	rd_latency_a: assert property (ar_taken |-> ##2 s_axi_rvalid)
		else $error("read answer late");
	wr_latency_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	ofs_upper_a: assert property (ar_taken and s_axi_araddr == {rpm_pkg::IDX_START_OFS, 2'b00} |-> ##2 s_axi_rdata[31:6] == 26'h0)
		else $error("offset upper bits not zero");
	unmapped_rd_a: assert property (ar_taken and s_axi_araddr == 12'h580 |-> ##2 s_axi_rresp == rpm_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	done_pulse_a: assert property (match_done |=> !match_done)
		else $error("compare done longer than one cycle");
	match_hold_a: assert property ($changed(match) |-> match_done)
		else $error("match changed outside compare end");
endmodule
`default_nettype wire

//--- verif/rpm_top_test.sv
/*
 Self-checking bench for rpm_top: register access over AXI4-Lite and
 frame compares. Assumes rpm_pkg is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rpm_top_test;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic rx_sof, rx_valid, rx_eof, match, match_done;
	logic [7:0] rx_byte;
	logic [7:0] pat [64];
	logic [7:0] fr [130];
	logic [63:0] msk;
	int miscompares, samples_checked, done_cnt, ofs, k;
	rpm_top i_rpm_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.rx_sof(rx_sof), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eof(rx_eof), .match(match),
		.match_done(match_done));
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (match_done === 1'b1)
			done_cnt <= done_cnt + 1;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Both halves offered together; each released at its own handshake
	task automatic wr(input logic [9:0] idx, input logic [31:0] v, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
	endtask
	task automatic rdr(input logic [9:0] idx, output logic [31:0] v, output logic [1:0] r);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	// One trailing byte carries the end mark, so the compare window is whole
	task automatic send_frame(input int len);
		int n0;
		n0 = done_cnt;
		for (int i = 0; i < len; i++) begin
			rx_valid <= 1'b1;
			rx_sof <= (i == 0);
			rx_eof <= (i == len - 1);
			rx_byte <= fr[i];
			@(posedge aclk);
		end
		rx_valid <= 1'b0;
		rx_sof <= 1'b0;
		rx_eof <= 1'b0;
		while (done_cnt == n0)
			@(posedge aclk);
		@(posedge aclk);
	endtask
	function automatic logic exp_match(input int o);
		for (int i = 0; i < 64; i++)
			if (!msk[i] && fr[o + i] !== pat[i])
				return 1'b0;
		return 1'b1;
	endfunction
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hf;
		{rx_sof, rx_valid, rx_eof, rx_byte} = 11'h000;
		void'($urandom(30));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int j = 0; j < 4; j++) begin
			rdr(rpm_pkg::IDX_MASK_0_15 + 10'(j), rd, resp);
			check(rd, 32'h0);
		end
		rdr(rpm_pkg::IDX_START_OFS, rd, resp);
		check(rd, 32'h0);
		for (int j = 0; j < 36; j++) begin
			d = $urandom;
			wr(rpm_pkg::IDX_PAT_FIRST + 10'(j), d, resp);
			check(resp, rpm_pkg::RESP_OKAY);
			rdr(rpm_pkg::IDX_PAT_FIRST + 10'(j), rd, resp);
			check(rd[15:0], d[15:0]);
		end
		wr(rpm_pkg::IDX_PAT_58_59, 32'h1234, resp);
		s_axi_wstrb <= 4'h2;
		wr(rpm_pkg::IDX_PAT_58_59, 32'habcd, resp);
		s_axi_wstrb <= 4'hf;
		rdr(rpm_pkg::IDX_PAT_58_59, rd, resp);
		check(rd, 32'hab34);
		wr(rpm_pkg::IDX_START_OFS, 32'hffffffff, resp);
		rdr(rpm_pkg::IDX_START_OFS, rd, resp);
		check(rd, 32'h3f);
		wr(10'h160, 32'h1234, resp);
		check(resp, rpm_pkg::RESP_SLVERR);
		rdr(10'h160, rd, resp);
		check(resp, rpm_pkg::RESP_SLVERR);
		for (int t = 0; t < 4; t++) begin
			ofs = (t == 0) ? 0 : (t == 1) ? 63 : $urandom_range(62, 1);
			msk = 64'h0;
			for (int i = 0; i < 130; i++)
				fr[i] = $urandom;
			for (int i = 0; i < 64; i++) begin
				pat[i] = $urandom;
				fr[ofs + i] = pat[i];
			end
			for (int j = 0; j < 32; j++)
				wr(rpm_pkg::IDX_PAT_FIRST + 10'(j), {16'h0, pat[2 * j + 1], pat[2 * j]}, resp);
			for (int j = 0; j < 4; j++)
				wr(rpm_pkg::IDX_MASK_0_15 + 10'(j), 32'h0, resp);
			wr(rpm_pkg::IDX_START_OFS, 32'(ofs), resp);
			send_frame(ofs + 65);
			check(match, exp_match(ofs));
			k = (t == 0) ? 63 : $urandom_range(63, 0);
			fr[ofs + k] = ~pat[k];
			send_frame(ofs + 65);
			check(match, exp_match(ofs));
			msk[k] = 1'b1;
			wr(rpm_pkg::IDX_MASK_0_15 + 10'(k / 16), {16'h0, msk[16 * (k / 16) +: 16]}, resp);
			send_frame(ofs + 65);
			check(match, exp_match(ofs));
			send_frame(ofs + 10);
			check(match, 1'b0);
		end
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		wrap_up;
	end
endmodule
bind rpm_top rpm_top_checker i_rpm_top_checker (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .match(match), .match_done(match_done));
`default_nettype wire
